// [logic/mode_cfg_regs.svh]
// timing counts, reset values and clock figures of the mode and slot logic
`ifndef MODE_CFG_REGS_SVH
`define MODE_CFG_REGS_SVH
`define MCLK_HZ 50000000
`define MCLK_MHZ 50
`define NS_PER_S 1000000000
`define FRAME_US 125
`define SLIP_LONG_US 50
`define SLIP_SHORT_US 25
`define ALIGN_TOL_US 50
`define PCK_FAST_HZ 32000
`define PCK_SLOW_HZ 16000
`define PCK_FAST_HALF (`MCLK_HZ / (2 * `PCK_FAST_HZ))
`define PCK_SLOW_HALF (`MCLK_HZ / (2 * `PCK_SLOW_HZ))
`define LINE_REF_HZ 1536000
`define FSC_HZ 8000
`define DCL_PER_FRAME (`LINE_REF_HZ / `FSC_HZ)
`define FSC_HIGH_DCL 2
`define NCO_INC ((64'(`LINE_REF_HZ) << 32) / 64'(`MCLK_HZ))
`define PLL_STEP_NS 65
`define PLL_STEP ((64'(`PLL_STEP_NS) * 64'(`LINE_REF_HZ) << 32) / 64'(`NS_PER_S))
`define CFG_RST 5'h00
`define SLOT_LAST_BIT 5'h1f
`endif

// [logic/mode_cfg_pkg.sv]
// types shared by the mode and slot logic
package mode_cfg_pkg;
  typedef enum logic [1:0] {
    subscriber_line_mode,
    network_term_mode,
    trunk_line_mode,
    terminal_mode
  } op_mode_t;
  typedef struct packed {
    logic state_machine_override;
    logic stop_go_output_enable;
    logic collision_handling_select;
    logic dual_use_config_bit;
    logic mode_config_bit;
  } cfg_t;
  typedef logic [31:0] slot_word_t;
endpackage

// [logic/slot_engine.sv]
// terminal bus slot engine on the data clock
`timescale 1ns/100ps
`default_nettype none
`include "mode_cfg_regs.svh"
module slot_engine (
  input wire logic data_clock_in,
  input wire logic srst_in,
  input wire logic frame_sync_in,
  input wire logic dd_in,
  input wire logic [2:0] slot_select_in,
  input wire logic nt_mode_in,
  input wire mode_cfg_pkg::slot_word_t tx_word_in,
  input wire logic tx_tgl_in,
  output mode_cfg_pkg::slot_word_t rx_word_out,
  output logic rx_tgl_out,
  output logic tx_ack_out,
  output logic du_oe_out
);
  logic [1:0] rst_s;
  logic rst;
  logic [1:0] nt_s;
  logic [1:0] tg_s;
  logic [2:0] ts1_q, ts2_q, ts3_q, ts_q;
  logic fsc_q;
  logic fsc_rise;
  logic [9:0] hb_q;
  logic [8:0] bit_idx;
  logic [2:0] chan;
  logic in_slot;
  mode_cfg_pkg::slot_word_t tx_q, rx_sh_q;

  // the reset comes from the main clock, so it is retimed here first
  always_ff @(posedge data_clock_in) begin
    rst_s <= {rst_s[0], srst_in};
    nt_s <= {nt_s[0], nt_mode_in};
    tg_s <= {tg_s[0], tx_tgl_in};
  end
  assign rst = rst_s[1];

  // pins are never latched; a filtered change moves the slot at once
  always_ff @(posedge data_clock_in) begin
    ts1_q <= slot_select_in;
    ts2_q <= ts1_q;
    ts3_q <= ts2_q;
    if (rst) begin
      ts_q <= 3'h0;
    end else begin
      ts_q <= (ts2_q & ~(ts2_q ^ ts3_q)) | (ts_q & (ts2_q ^ ts3_q));
    end
  end

  assign fsc_rise = frame_sync_in & ~fsc_q;
  assign bit_idx = hb_q[9:1];
  assign chan = nt_s[1] ? 3'h0 : ts_q;
  assign in_slot = (bit_idx[8] == 1'b0) && (bit_idx[7:5] == chan);

  always_ff @(posedge data_clock_in) begin
    if (rst) begin
      fsc_q <= 1'b0;
      hb_q <= 10'h000;
    end else begin
      fsc_q <= frame_sync_in;
      if (fsc_rise) begin
        hb_q <= 10'h000;
      end else begin
        hb_q <= hb_q + 10'h001;
      end
    end
  end

  // a new upstream word is taken at most once per frame, at the frame start
  always_ff @(posedge data_clock_in) begin
    if (rst) begin
      tx_q <= '1;
      tx_ack_out <= 1'b0;
    end else if (fsc_rise && (tg_s[1] != tx_ack_out)) begin
      tx_q <= tx_word_in;
      tx_ack_out <= tg_s[1];
    end
  end

  // open drain: only a zero bit inside the own slot pulls the line
  always_ff @(posedge data_clock_in) begin
    if (rst) begin
      du_oe_out <= 1'b0;
    end else begin
      du_oe_out <= in_slot & ~tx_q[~bit_idx[4:0]];
    end
  end

  always_ff @(posedge data_clock_in) begin
    if (rst) begin
      rx_sh_q <= '0;
      rx_word_out <= '0;
      rx_tgl_out <= 1'b0;
    end else if (in_slot && hb_q[0]) begin
      rx_sh_q <= {rx_sh_q[30:0], dd_in};
      if (bit_idx[4:0] == `SLOT_LAST_BIT) begin
        rx_word_out <= {rx_sh_q[30:0], dd_in};
        rx_tgl_out <= ~rx_tgl_out;
      end
    end
  end

  default clocking cb @(posedge data_clock_in); endclocking
  default disable iff (rst);

  chk_bit_clear: assert property (fsc_rise |=> hb_q == 10'h000)
    else $error("bit counter not cleared by frame sync");
  chk_du_slot: assert property (du_oe_out |-> $past(in_slot))
    else $error("upstream driven outside own slot");
  chk_nt_chan: assert property (nt_s[1] && du_oe_out |-> $past(hb_q[9:6]) == 4'h0)
    else $error("network termination not in channel 0");
  chk_rx_slot_end: assert property ($changed(rx_tgl_out) |-> $past(hb_q[5:0]) == 6'h3f && $past(in_slot))
    else $error("downstream word ended off slot boundary");
endmodule
`default_nettype wire

// [logic/mode_config_slot_select.sv]
// mode configuration, clocking and slot selection of the line transceiver
`timescale 1ns/100ps
`default_nettype none
`include "mode_cfg_regs.svh"
module mode_config_slot_select #(
  parameter int unsigned FRAME_CYC = `FRAME_US * `MCLK_MHZ
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic soft_reset_in,
  input wire logic [1:0] mode_strap_in,
  input wire logic nt_bus_strap_valid_in,
  input wire logic nt_bus_strap_in,
  input wire logic ext_base_clock_in,
  input wire mode_cfg_pkg::cfg_t cfg_in,
  input wire logic cfg_write_in,
  input wire logic data_clock_in,
  input wire logic frame_sync_in,
  input wire logic dd_in,
  input wire logic [2:0] slot_select_in,
  input wire logic line_frame_in,
  input wire logic line_early_in,
  input wire logic line_late_in,
  input wire logic line_signal_in,
  input wire logic echo_stop_in,
  input wire mode_cfg_pkg::slot_word_t tx_word_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output mode_cfg_pkg::slot_word_t rx_word_out,
  output logic rx_valid_out,
  output logic du_out,
  output logic du_oe_out,
  output logic data_clock_out,
  output logic frame_sync_out,
  output logic bus_clock_oe_out,
  output logic line_clock_out,
  output logic line_clock_oe_out,
  output logic power_clock_out,
  output logic power_clock_oe_out,
  output logic slip_warn_out,
  output logic frame_aligned_out,
  output logic transmit_pll_locked_out,
  output logic power_up_out,
  output logic power_down_out,
  output logic bus_config_out,
  output logic aux_gpio_only_out,
  output logic nt_state_machine_out,
  output logic aux_pin_five_out,
  output logic collision_mode_out,
  output mode_cfg_pkg::op_mode_t mode_out
);
  localparam logic [12:0] FRM = 13'(FRAME_CYC);
  localparam logic [12:0] FRM_HALF = 13'(FRAME_CYC / 2);
  localparam logic [12:0] SLIP_LONG = 13'(`SLIP_LONG_US * `MCLK_MHZ);
  localparam logic [12:0] SLIP_SHORT = 13'(`SLIP_SHORT_US * `MCLK_MHZ);
  localparam logic [12:0] ALIGN_TOL = 13'(`ALIGN_TOL_US * `MCLK_MHZ);
  localparam logic [10:0] PCK_FAST = 11'(`PCK_FAST_HALF);
  localparam logic [10:0] PCK_SLOW = 11'(`PCK_SLOW_HALF);
  localparam logic [31:0] NCO_INC = 32'(`NCO_INC);
  localparam logic [31:0] PLL_STEP = 32'(`PLL_STEP);
  localparam logic [7:0] DCL_FRM = 8'(`DCL_PER_FRAME);
  localparam logic [7:0] FSC_HI = 8'(`FSC_HIGH_DCL);

  logic strap_take_q;
  logic nt_strap_v_q, nt_strap_q;
  mode_cfg_pkg::cfg_t cfg_q;
  logic is_lts, is_nt, is_ltt, is_te;
  logic [1:0] a1_q, a2_q, a3_q, af_q;
  logic async_in [2];
  logic fsc_p_q, lvl_p_q, fsc_edge;
  logic [31:0] nco_q;
  logic nco_p_q, nco_rise;
  logic [7:0] dcnt_q;
  logic lck_half_q;
  logic [10:0] pc_cnt_q, pc_half;
  logic [12:0] wc_q, wdist, fr_q, fr2;
  logic transmit_pll_on;
  logic tx_tgl_q;
  logic [1:0] ack_s;
  logic [2:0] rx_s;
  logic eng_ack, eng_rx_tgl;
  mode_cfg_pkg::slot_word_t tx_word_q, eng_rx_word;

  // straps are caught on the first edge after a hard reset only
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      strap_take_q <= 1'b1;
      mode_out <= mode_cfg_pkg::subscriber_line_mode;
      nt_strap_v_q <= 1'b0;
      nt_strap_q <= 1'b0;
    end else if (strap_take_q) begin
      strap_take_q <= 1'b0;
      mode_out <= mode_cfg_pkg::op_mode_t'(mode_strap_in);
      nt_strap_v_q <= nt_bus_strap_valid_in;
      nt_strap_q <= nt_bus_strap_in;
    end
  end

  assign is_lts = (mode_out == mode_cfg_pkg::subscriber_line_mode);
  assign is_nt = (mode_out == mode_cfg_pkg::network_term_mode);
  assign is_ltt = (mode_out == mode_cfg_pkg::trunk_line_mode);
  assign is_te = (mode_out == mode_cfg_pkg::terminal_mode);

  always_ff @(posedge mclk_in) begin
    if (srst_in || soft_reset_in) begin
      cfg_q <= `CFG_RST;
    end else if (cfg_write_in) begin
      cfg_q <= cfg_in;
    end
  end

  // frame sync and line level: three stages, change taken when two agree
  assign async_in[0] = frame_sync_in;
  assign async_in[1] = line_signal_in;
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge mclk_in) begin
      a1_q[i] <= async_in[i];
      a2_q[i] <= a1_q[i];
      a3_q[i] <= a2_q[i];
      if (srst_in) begin
        af_q[i] <= 1'b0;
      end else if (a2_q[i] == a3_q[i]) begin
        af_q[i] <= a2_q[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fsc_p_q <= 1'b0;
      lvl_p_q <= 1'b0;
      power_up_out <= 1'b0;
      power_down_out <= 1'b0;
    end else begin
      fsc_p_q <= af_q[0];
      lvl_p_q <= af_q[1];
      power_up_out <= af_q[1] & ~lvl_p_q;
      power_down_out <= ~af_q[1] & lvl_p_q;
    end
  end
  assign fsc_edge = af_q[0] & ~fsc_p_q;

  // line reference oscillator, nudged by one 65 ns step per correction
  always_ff @(posedge mclk_in) begin
    if (srst_in || !(is_te || is_ltt)) begin
      nco_q <= 32'h0000_0000;
      nco_p_q <= 1'b0;
    end else begin
      nco_p_q <= nco_q[31];
      case ({line_early_in, line_late_in})
        2'b10: nco_q <= nco_q + NCO_INC + PLL_STEP;
        2'b01: nco_q <= nco_q + NCO_INC - PLL_STEP;
        default: nco_q <= nco_q + NCO_INC;
      endcase
    end
  end
  assign nco_rise = nco_q[31] & ~nco_p_q;

  // terminal mode makes the bus clocks from the recovered line timing
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dcnt_q <= 8'h00;
      lck_half_q <= 1'b0;
      data_clock_out <= 1'b0;
      frame_sync_out <= 1'b0;
      bus_clock_oe_out <= 1'b0;
      line_clock_out <= 1'b0;
      line_clock_oe_out <= 1'b0;
    end else begin
      if (nco_rise) begin
        dcnt_q <= (dcnt_q == DCL_FRM - 8'h01) ? 8'h00 : dcnt_q + 8'h01;
        lck_half_q <= ~lck_half_q;
      end
      data_clock_out <= is_te & nco_q[31];
      frame_sync_out <= is_te && (dcnt_q < FSC_HI);
      bus_clock_oe_out <= is_te;
      line_clock_out <= is_te ? lck_half_q : (is_ltt & nco_q[31]);
      line_clock_oe_out <= is_te | is_ltt;
    end
  end

  assign pc_half = cfg_q.dual_use_config_bit ? PCK_SLOW : PCK_FAST;
  always_ff @(posedge mclk_in) begin
    if (srst_in || !is_te) begin
      pc_cnt_q <= 11'h000;
      power_clock_out <= 1'b0;
      power_clock_oe_out <= 1'b0;
    end else begin
      power_clock_oe_out <= 1'b1;
      if (pc_cnt_q >= pc_half - 11'h001) begin
        pc_cnt_q <= 11'h000;
        power_clock_out <= ~power_clock_out;
      end else begin
        pc_cnt_q <= pc_cnt_q + 11'h001;
      end
    end
  end

  // wander is the distance of the line frame from the nearest sync edge
  assign wdist = (wc_q < FRM_HALF) ? wc_q : 13'(FRM - wc_q);
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wc_q <= 13'h0000;
      slip_warn_out <= 1'b0;
      frame_aligned_out <= 1'b0;
    end else begin
      if (fsc_edge) begin
        wc_q <= 13'h0000;
      end else if (wc_q != FRM - 13'h0001) begin
        wc_q <= wc_q + 13'h0001;
      end
      slip_warn_out <= 1'b0;
      if (!is_ltt) begin
        frame_aligned_out <= 1'b0;
      end else if (line_frame_in) begin
        slip_warn_out <= wdist >= (cfg_q.dual_use_config_bit ? SLIP_SHORT : SLIP_LONG);
        frame_aligned_out <= wdist <= ALIGN_TOL;
      end
    end
  end

  // transmit PLL: the crystal frame slips one cycle per frame toward sync
  assign transmit_pll_on = is_lts | (is_nt & ~ext_base_clock_in);
  assign fr2 = fr_q + 13'h0002;
  always_ff @(posedge mclk_in) begin
    if (srst_in || !transmit_pll_on) begin
      fr_q <= 13'h0000;
      transmit_pll_locked_out <= 1'b0;
    end else if (fsc_edge) begin
      transmit_pll_locked_out <= (fr_q == 13'h0000) || (fr_q == FRM - 13'h0001);
      if (fr_q == 13'h0000) begin
        fr_q <= 13'h0001;
      end else if (fr_q < FRM_HALF) begin
        fr_q <= fr_q;
      end else begin
        fr_q <= (fr2 >= FRM) ? 13'(fr2 - FRM) : fr2;
      end
    end else begin
      fr_q <= (fr_q == FRM - 13'h0001) ? 13'h0000 : fr_q + 13'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      bus_config_out <= 1'b0;
      aux_gpio_only_out <= 1'b0;
      nt_state_machine_out <= 1'b0;
      aux_pin_five_out <= 1'b0;
      collision_mode_out <= 1'b0;
    end else begin
      if (is_nt && nt_strap_v_q) begin
        bus_config_out <= nt_strap_q;
      end else begin
        bus_config_out <= (is_nt | is_lts) & cfg_q.dual_use_config_bit;
      end
      aux_gpio_only_out <= (is_nt | is_te) & cfg_q.mode_config_bit;
      nt_state_machine_out <= is_nt | (is_lts & cfg_q.state_machine_override);
      aux_pin_five_out <= is_te & cfg_q.stop_go_output_enable & echo_stop_in;
      collision_mode_out <= cfg_q.collision_handling_select;
    end
  end

  // word crossing: toggle handshake, the word stands until acknowledged
  always_ff @(posedge mclk_in) begin
    ack_s <= {ack_s[0], eng_ack};
    rx_s <= {rx_s[1:0], eng_rx_tgl};
    if (srst_in) begin
      tx_tgl_q <= 1'b0;
      tx_word_q <= '1;
      tx_ready_out <= 1'b0;
      rx_word_out <= '0;
      rx_valid_out <= 1'b0;
      du_out <= 1'b0;
    end else begin
      du_out <= 1'b0;
      if (tx_valid_in && tx_ready_out) begin
        tx_tgl_q <= ~tx_tgl_q;
        tx_word_q <= tx_word_in;
      end
      tx_ready_out <= !(tx_valid_in && tx_ready_out) && (ack_s[1] == tx_tgl_q);
      rx_valid_out <= rx_s[1] ^ rx_s[2];
      if (rx_s[1] ^ rx_s[2]) begin
        rx_word_out <= eng_rx_word;
      end
    end
  end

  slot_engine u_slot (
    .data_clock_in(data_clock_in),
    .srst_in(srst_in),
    .frame_sync_in(frame_sync_in),
    .dd_in(dd_in),
    .slot_select_in(slot_select_in),
    .nt_mode_in(nt_state_machine_out),
    .tx_word_in(tx_word_q),
    .tx_tgl_in(tx_tgl_q),
    .rx_word_out(eng_rx_word),
    .rx_tgl_out(eng_rx_tgl),
    .tx_ack_out(eng_ack),
    .du_oe_out(du_oe_out)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chk_cfg_clear: assert property (soft_reset_in |=> cfg_q == `CFG_RST)
    else $error("configuration not cleared by soft reset");
  chk_slip_level: assert property (is_ltt && line_frame_in && wdist >= SLIP_SHORT
      && wdist < SLIP_LONG |=> slip_warn_out == $past(cfg_q.dual_use_config_bit))
    else $error("slip threshold wrong");
  chk_pck_idle: assert property (!is_te |=> !power_clock_out && !power_clock_oe_out)
    else $error("power clock active outside terminal mode");
  chk_bus_strap: assert property (is_nt && nt_strap_v_q |=> bus_config_out == $past(nt_strap_q))
    else $error("strap did not override bus selection");
  chk_aux_gpio: assert property (is_lts || is_ltt |=> !aux_gpio_only_out)
    else $error("aux pins set to plain I/O in wrong mode");
  chk_stop_go: assert property (is_te && cfg_q.stop_go_output_enable && echo_stop_in
      |=> aux_pin_five_out)
    else $error("stop not shown on aux pin five");
  chk_fsm_sel: assert property (is_lts && cfg_q.state_machine_override |=> nt_state_machine_out)
    else $error("override did not pick network machine");
  chk_line_ref: assert property (is_ltt |=> line_clock_oe_out && !bus_clock_oe_out)
    else $error("trunk clocking drive wrong");
  chk_level_up: assert property ($rose(af_q[1]) |=> power_up_out ##1 !power_up_out)
    else $error("power up request missing");
  chk_tx_once: assert property (tx_ready_out && tx_valid_in |=> !tx_ready_out)
    else $error("second word taken before acknowledge");
endmodule
`default_nettype wire

// [bench/bus_ctrl_model.sv]
// far-side bus controller model: data clock, frame sync, downstream words, upstream capture
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model (
  output logic data_clock_out,
  output logic frame_sync_out,
  output logic dd_out,
  input wire logic du_oe_in,
  input wire logic [2:0] exp_slot_in,
  input wire logic [31:0] dd_base_in,
  output logic [31:0] du_word_out,
  output int stray_out
);
  int half = 0;
  int nh;
  logic [31:0] sh = 32'h0;
  logic [31:0] w;
  // the bus clock runs free, as the far side supplies it even between frames
  initial begin
    data_clock_out = 1'h0;
    frame_sync_out = 1'h0;
    dd_out = 1'h1;
    du_word_out = 32'hffff_ffff;
    stray_out = 0;
    #3;
    forever #7.5 data_clock_out = ~data_clock_out;
  end
  // 512 half-bits a frame, eight 32-bit slots, bit 31 first
  always @(negedge data_clock_out) begin
    if (half % 2 == 1) begin
      sh = {sh[30:0], ~du_oe_in};  // pull-up holds a released line high
      if (du_oe_in === 1'h1 && (half / 64) != exp_slot_in) begin
        stray_out <= stray_out + 1;
      end
      if (half % 64 == 63 && (half / 64) == exp_slot_in) begin
        du_word_out <= sh;
      end
    end
    nh = (half == 511) ? 0 : half + 1;
    half <= nh;
    frame_sync_out <= (nh < 4);  // four data clocks (two bits) high at frame start
    // the block counts half-bits one edge behind frame sync, so the bit of the
    // ending half is put out: it then stands at the sampling edge of that bit
    w = dd_base_in ^ 32'(half / 64);
    dd_out <= w[31 - (half % 64) / 2];
  end
endmodule
`default_nettype wire

// [bench/mode_config_slot_select_test.sv]
// self-checking bench for mode configuration and slot selection
`timescale 1ns/100ps
`default_nettype none
`include "mode_cfg_regs.svh"
module mode_config_slot_select_test;
  logic mclk_in = 1'h0;
  logic srst_in = 1'h1;
  logic soft_reset_in = 1'h0;
  logic [1:0] mode_strap_in = 2'h0;
  logic strap_valid = 1'h0;
  mode_cfg_pkg::cfg_t cfg_in = '0;
  logic cfg_write_in = 1'h0;
  logic [2:0] slot_select_in = 3'h0;
  logic line_frame_in = 1'h0;
  logic line_signal_in = 1'h0;
  logic echo_stop_in = 1'h0;
  mode_cfg_pkg::slot_word_t tx_word_in = '0;
  logic tx_valid_in = 1'h0;
  logic [2:0] exp_slot = 3'h0;
  logic [31:0] dd_base = 32'hc3a5_0f10;
  logic data_clock, frame_sync, dd, du_oe_out, tx_ready_out, rx_valid_out;
  logic bus_clock_oe_out, line_clock_oe_out, power_clock_out, power_clock_oe_out;
  logic slip_warn_out, frame_aligned_out, power_up_out, power_down_out;
  logic bus_config_out, aux_gpio_only_out, nt_state_machine_out, aux_pin_five_out;
  logic collision_mode_out;
  mode_cfg_pkg::slot_word_t rx_word_out;
  mode_cfg_pkg::op_mode_t mode_out;
  logic [31:0] du_word;
  int stray, stray_mark, cnt;
  int mismatches = 0;
  int samples_checked = 0;

  mode_config_slot_select #(.FRAME_CYC(384)) mode_config_slot_select_i (
    .mclk_in(mclk_in), .srst_in(srst_in), .soft_reset_in(soft_reset_in),
    .mode_strap_in(mode_strap_in), .nt_bus_strap_valid_in(strap_valid),
    .nt_bus_strap_in(1'h0), .ext_base_clock_in(1'h0), .cfg_in(cfg_in),
    .cfg_write_in(cfg_write_in), .data_clock_in(data_clock), .frame_sync_in(frame_sync),
    .dd_in(dd), .slot_select_in(slot_select_in), .line_frame_in(line_frame_in),
    .line_early_in(1'h0), .line_late_in(1'h0), .line_signal_in(line_signal_in),
    .echo_stop_in(echo_stop_in), .tx_word_in(tx_word_in), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .rx_word_out(rx_word_out), .rx_valid_out(rx_valid_out),
    .du_out(), .du_oe_out(du_oe_out), .data_clock_out(), .frame_sync_out(),
    .bus_clock_oe_out(bus_clock_oe_out), .line_clock_out(),
    .line_clock_oe_out(line_clock_oe_out), .power_clock_out(power_clock_out),
    .power_clock_oe_out(power_clock_oe_out), .slip_warn_out(slip_warn_out),
    .frame_aligned_out(frame_aligned_out), .transmit_pll_locked_out(), .power_up_out(power_up_out),
    .power_down_out(power_down_out), .bus_config_out(bus_config_out),
    .aux_gpio_only_out(aux_gpio_only_out), .nt_state_machine_out(nt_state_machine_out),
    .aux_pin_five_out(aux_pin_five_out), .collision_mode_out(collision_mode_out),
    .mode_out(mode_out)
  );

  bus_ctrl_model bus_ctrl_model_i (
    .data_clock_out(data_clock), .frame_sync_out(frame_sync), .dd_out(dd),
    .du_oe_in(du_oe_out), .exp_slot_in(exp_slot), .dd_base_in(dd_base),
    .du_word_out(du_word), .stray_out(stray)
  );

  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hard_reset(input logic [1:0] m);
    @(negedge mclk_in);
    srst_in = 1'h1;
    mode_strap_in = m;
    repeat (4) @(negedge mclk_in);
    srst_in = 1'h0;
    repeat (3) @(negedge mclk_in);
  endtask

  task automatic write_cfg(input mode_cfg_pkg::cfg_t c);
    cfg_in = c;
    cfg_write_in = 1'h1;
    @(negedge mclk_in);
    cfg_write_in = 1'h0;
    repeat (3) @(negedge mclk_in);
  endtask

  task automatic wait_rx;
    int i;
    for (i = 0; i < 1000 && rx_valid_out !== 1'h1; i++) @(negedge mclk_in);
    check_bit(rx_valid_out, 1'h1, "downstream word strobe");
    @(negedge mclk_in);
  endtask

  // one upstream word out and two downstream words in, on the given pins
  task automatic slot_trial(input logic [2:0] pins, input logic [2:0] slot, input logic [31:0] w);
    int i;
    slot_select_in = pins;
    exp_slot = slot;
    tx_word_in = w;
    tx_valid_in = 1'h1;
    for (i = 0; i < 3000 && tx_ready_out !== 1'h1; i++) @(negedge mclk_in);
    @(negedge mclk_in);
    tx_valid_in = 1'h0;
    for (i = 0; i < 3000 && du_word !== w; i++) @(negedge mclk_in);
    check_word(du_word, w, "upstream slot word");
    stray_mark = stray;
    repeat (2) wait_rx();
    check_word(rx_word_out, dd_base ^ 32'(slot), "downstream slot word");
    check_word(32'(stray), 32'(stray_mark), "upstream drive outside slot");
  endtask

  // counts mclk cycles from the call up to the next rise of the power clock
  task automatic wait_rise(output int c);
    logic p;
    c = 0;
    p = power_clock_out;
    while (c < 8000 && !(p === 1'h0 && power_clock_out === 1'h1)) begin
      p = power_clock_out;
      @(negedge mclk_in);
      c++;
    end
  endtask

  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  // the full run needs about 0.4 ms
  initial begin
    #1500000;
    mismatches++;
    summarize();
  end

  initial begin
    hard_reset(2'h0);
    check_word(32'(mode_out), 32'(mode_cfg_pkg::subscriber_line_mode), "mode");
    check_bit(bus_config_out | aux_gpio_only_out | nt_state_machine_out, 1'h0, "cfg");
    slot_trial(3'h0, 3'h0, 32'h1234_5678);
    slot_trial(3'h3, 3'h3, 32'h8000_0001);
    slot_trial(3'h7, 3'h7, 32'hfe01_7f80);
    write_cfg(5'h16); // override, collision select and dual bit
    check_bit(bus_config_out, 1'h1, "bus select");
    check_bit(nt_state_machine_out, 1'h1, "nt machine");
    check_bit(collision_mode_out, 1'h1, "collision select");
    slot_trial(3'h5, 3'h0, 32'h0f0f_a5a5);
    mode_strap_in = 2'h2;
    repeat (3) @(negedge mclk_in);
    check_word(32'(mode_out), 32'(mode_cfg_pkg::subscriber_line_mode), "mode kept");
    soft_reset_in = 1'h1;
    @(negedge mclk_in);
    soft_reset_in = 1'h0;
    repeat (3) @(negedge mclk_in);
    check_bit(bus_config_out | nt_state_machine_out | collision_mode_out, 1'h0, "soft");
    strap_valid = 1'h1;
    hard_reset(2'h1);
    write_cfg(5'h03);
    check_bit(bus_config_out, 1'h0, "strap over bus bit");
    check_bit(aux_gpio_only_out, 1'h1, "aux plain io");
    slot_trial(3'h5, 3'h0, 32'h5555_aaaa);
    strap_valid = 1'h0;
    hard_reset(2'h2);
    check_bit(line_clock_oe_out & ~bus_clock_oe_out, 1'h1, "trunk clocking");
    write_cfg(5'h06); // collision select with short slip threshold
    check_bit(collision_mode_out, 1'h1, "collision select");
    line_frame_in = 1'h1;
    @(negedge mclk_in);
    line_frame_in = 1'h0;
    // the slip flag stands for one cycle only, so it is looked at here
    check_bit(slip_warn_out, 1'h0, "slip within threshold");
    repeat (3) @(negedge mclk_in);
    check_bit(frame_aligned_out, 1'h1, "frame aligned");
    hard_reset(2'h3);
    check_bit(bus_clock_oe_out & power_clock_oe_out, 1'h1, "terminal clocks");
    write_cfg(5'h09); // stop/go enable and mode bit, collision select kept 0
    echo_stop_in = 1'h1;
    repeat (3) @(negedge mclk_in);
    check_bit(aux_pin_five_out, 1'h1, "stop");
    echo_stop_in = 1'h0;
    repeat (3) @(negedge mclk_in);
    check_bit(aux_pin_five_out, 1'h0, "go");
    check_bit(aux_gpio_only_out, 1'h1, "aux plain io");
    repeat (3) wait_rise(cnt);
    check_word(32'(cnt), 32'(2 * `PCK_FAST_HALF), "fast power clock");
    write_cfg(5'h0b);
    repeat (3) wait_rise(cnt);
    check_word(32'(cnt), 32'(2 * `PCK_SLOW_HALF), "slow power clock");
    line_signal_in = 1'h1;
    for (cnt = 0; cnt < 2000 && power_up_out !== 1'h1; cnt++) @(negedge mclk_in);
    check_bit(power_up_out, 1'h1, "power up");
    line_signal_in = 1'h0;
    for (cnt = 0; cnt < 2000 && power_down_out !== 1'h1; cnt++) @(negedge mclk_in);
    check_bit(power_down_out, 1'h1, "power down");
    summarize();
  end
endmodule
`default_nettype wire
